// ===== src/opt_one_pulse_timer.sv
// one-pulse pwm generator on the second 12-bit autoreload counter
// Behaviour
// - one-pulse only in dual mode, counter two, enabled
// - edge select bit picks active trigger polarity
// - active edge clears counter, output three high
// - output three low at duty three match
// - edges ignored before duty match reached after a triggered restart
// - edge after duty match restarts pulse
// - no edge: count to reload, clear, repeat
// - output two same, uses duty two
// - enable and edge select act immediately
// - polarity inverts outputs in one-pulse mode only, loaded at overflow if transfer
// - trigger to clear within 2 to 3 cycles
// - break, trigger, force, reload, normal priority
// - overflow pulse on every counter clear
// - force update loads duty now, and polarity now in one-pulse mode
// - duty three update only at force or at a clear with transfer
// - edge after reload clear clears again
module opt_one_pulse_timer #(
  parameter int CntW = opt_pkg::CNT_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // mode control
  input wire logic dualTimerMode,
  input wire logic counterTwoEnable,
  input wire logic onePulseEnable,
  input wire logic triggerEdgeSelect,
  input wire logic breakActive,
  input wire logic counterTick,
  // compare and reload
  input wire logic [CntW-1:0] reloadValueTwo,
  input wire logic [CntW-1:0] dutyCompareTwo,
  input wire logic [CntW-1:0] dutyCompareThree,
  input wire logic outputPolarityTwo,
  input wire logic outputPolarityThree,
  input wire logic transferEnableTwo,
  input wire logic forceUpdateTwo,
  // trigger pin
  input wire logic captureTriggerPin,
  // outputs
  output logic pulseOutTwo,
  output logic pulseOutThree,
  output logic overflowTwo,
  output logic [CntW-1:0] secondCounter
);

  // package constants are 12 bits wide, so wider counters cannot be served
  if (CntW < 2 || CntW > opt_pkg::CNT_W) begin : g_bad_width
    $error("opt_one_pulse_timer: CntW out of range");
  end

  logic [CntW-1:0] cnt_r;
  logic [CntW-1:0] activeDutyTwo_r;
  logic [CntW-1:0] activeDutyThree_r;
  logic activePolTwo_r;
  logic activePolThree_r;
  logic rawTwo_r;
  logic rawThree_r;
  logic pinPrev_r;
  logic trigPend_r;
  logic holdOff_r;
  logic ovf_r;
  logic onePulseOn;
  logic pinEdge;
  logic trigAccept;
  logic reloadHit;
  logic dutyPassed;
  logic clearCnt;
  opt_pkg::opt_event_t evt;

  //////////////////////////////////////////////////////////////////////////
  // mode qualification
  assign onePulseOn = dualTimerMode & onePulseEnable & counterTwoEnable;

  // polarity of active edge, select used live
  assign pinEdge = triggerEdgeSelect ? (captureTriggerPin & ~pinPrev_r)
                                     : (~captureTriggerPin & pinPrev_r);

  // ignore edges until duty three reached after a triggered restart
  // a reload clear does not arm the hold-off, so an edge still restarts
  assign dutyPassed = ~holdOff_r;
  assign reloadHit = counterTick & (cnt_r >= reloadValueTwo);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pinPrev_r <= 1'b0;
    end else begin
      pinPrev_r <= captureTriggerPin;
    end
  end

  // edge seen in cycle 0, pending in 1, clear in 2
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trigPend_r <= 1'b0;
    end else begin
      // a second edge while one is pending would restart twice
      trigPend_r <= onePulseOn & pinEdge & dutyPassed & ~trigPend_r;
    end
  end
  assign trigAccept = trigPend_r & onePulseOn;

  // hold-off set by triggered restart, ended by duty match or other clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      holdOff_r <= 1'b0;
    end else if (~onePulseOn) begin
      holdOff_r <= 1'b0;
    end else if (trigAccept & clearCnt) begin
      holdOff_r <= 1'b1;
    end else if (clearCnt) begin
      holdOff_r <= 1'b0;
    end else if (cnt_r >= activeDutyThree_r) begin
      holdOff_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // event priority, break above everything
  always_comb begin
    if (breakActive | ~counterTwoEnable) begin
      evt = opt_pkg::OPT_EV_NONE;
    end else if (forceUpdateTwo) begin
      evt = opt_pkg::OPT_EV_FORCE;
    end else if (reloadHit) begin
      evt = opt_pkg::OPT_EV_UNTRIG;
    end else begin
      evt = opt_pkg::OPT_EV_PWM;
    end
  end

  assign clearCnt = ~breakActive & counterTwoEnable
                    & (trigAccept | evt == opt_pkg::OPT_EV_FORCE
                       | evt == opt_pkg::OPT_EV_UNTRIG);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r <= opt_pkg::CNT_ZERO[CntW-1:0];
    end else if (clearCnt) begin
      cnt_r <= opt_pkg::CNT_ZERO[CntW-1:0];
    end else if (counterTwoEnable & counterTick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= clearCnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // force loads now in one-pulse mode, polarity also at overflow with transfer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      activePolTwo_r <= 1'b0;
      activePolThree_r <= 1'b0;
    end else if ((onePulseOn & forceUpdateTwo) | (clearCnt & transferEnableTwo)) begin
      activePolTwo_r <= outputPolarityTwo;
      activePolThree_r <= outputPolarityThree;
    end
  end

  // duty copies load on force, or on a counter clear with transfer enable
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      activeDutyTwo_r <= opt_pkg::DUTY_RST[CntW-1:0];
      activeDutyThree_r <= opt_pkg::DUTY_RST[CntW-1:0];
    end else if (forceUpdateTwo | (clearCnt & transferEnableTwo)) begin
      activeDutyTwo_r <= dutyCompareTwo;
      activeDutyThree_r <= dutyCompareThree;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs set on clear, drop at duty match
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rawTwo_r <= 1'b0;
      rawThree_r <= 1'b0;
    end else if (breakActive) begin
      rawTwo_r <= 1'b0;
      rawThree_r <= 1'b0;
    end else if (clearCnt) begin
      rawTwo_r <= 1'b1;
      rawThree_r <= 1'b1;
    end else begin
      if (cnt_r >= activeDutyTwo_r) begin
        rawTwo_r <= 1'b0;
      end
      if (cnt_r >= activeDutyThree_r) begin
        rawThree_r <= 1'b0;
      end
    end
  end

  // inversion applies only in one-pulse mode
  assign pulseOutTwo = rawTwo_r ^ (onePulseOn & activePolTwo_r);
  assign pulseOutThree = rawThree_r ^ (onePulseOn & activePolThree_r);
  assign overflowTwo = ovf_r;
  assign secondCounter = cnt_r;

  //////////////////////////////////////////////////////////////////////////
  sequence s_edge;
    onePulseOn & pinEdge & dutyPassed & ~trigPend_r & ~breakActive & counterTwoEnable;
  endsequence

  sequence s_reload_clear;
    reloadHit & ~trigAccept & ~breakActive & counterTwoEnable & onePulseOn;
  endsequence

  sequence s_cleared;
    ##[1:2] (cnt_r == '0);
  endsequence

  a_trigger_clear: assert property (@(posedge sys_clk) disable iff (srst)
    s_edge ##1 onePulseOn & ~breakActive & counterTwoEnable |-> s_cleared)
    else $error("trigger did not clear counter in time");

  a_clear_sets_out: assert property (@(posedge sys_clk) disable iff (srst)
    clearCnt |=> rawThree_r & rawTwo_r)
    else $error("clear did not raise outputs");

  a_ovf_on_clear: assert property (@(posedge sys_clk) disable iff (srst)
    clearCnt |=> ovf_r)
    else $error("overflow not flagged on clear");

  a_ovf_only_clear: assert property (@(posedge sys_clk) disable iff (srst)
    ovf_r |-> $past(clearCnt))
    else $error("overflow flagged without a clear");

  a_mode_gate: assert property (@(posedge sys_clk) disable iff (srst)
    ~onePulseOn |=> ~trigPend_r)
    else $error("trigger taken outside one-pulse mode");

  a_edge_select: assert property (@(posedge sys_clk) disable iff (srst)
    onePulseOn & pinEdge & ~holdOff_r & ~trigPend_r |=> trigPend_r)
    else $error("active edge not taken");

  a_restart_high: assert property (@(posedge sys_clk) disable iff (srst)
    trigAccept & ~breakActive & counterTwoEnable |=> cnt_r == '0 && rawThree_r && holdOff_r)
    else $error("triggered restart incomplete");

  a_two_drop: assert property (@(posedge sys_clk) disable iff (srst)
    ~breakActive & ~clearCnt & (cnt_r >= activeDutyTwo_r) |=> ~rawTwo_r)
    else $error("output two not dropped at duty");

  a_holdoff_end: assert property (@(posedge sys_clk) disable iff (srst)
    holdOff_r & ~breakActive & ~clearCnt & (cnt_r >= activeDutyThree_r) |=> ~holdOff_r)
    else $error("hold-off not released at duty");

  a_reload_rearm: assert property (@(posedge sys_clk) disable iff (srst)
    s_reload_clear |=> ~holdOff_r)
    else $error("reload clear left edges blocked");

  a_break_no_clear: assert property (@(posedge sys_clk) disable iff (srst)
    breakActive |-> ~clearCnt)
    else $error("counter cleared during break");

  a_transfer_pol: assert property (@(posedge sys_clk) disable iff (srst)
    clearCnt & transferEnableTwo |=> activePolTwo_r == $past(outputPolarityTwo)
      && activePolThree_r == $past(outputPolarityThree))
    else $error("polarity not transferred at overflow");

  a_duty_drop: assert property (@(posedge sys_clk) disable iff (srst)
    ~breakActive & ~clearCnt & (cnt_r >= activeDutyThree_r) |=> ~rawThree_r)
    else $error("output three not dropped at duty");

  a_ignore_early: assert property (@(posedge sys_clk) disable iff (srst)
    holdOff_r & counterTwoEnable & counterTick & ~reloadHit & ~forceUpdateTwo & ~trigPend_r
      |=> cnt_r != '0 || $past(cnt_r) == '1)
    else $error("early trigger affected counter");

  a_reload_wrap: assert property (@(posedge sys_clk) disable iff (srst)
    counterTwoEnable & ~breakActive & reloadHit |=> cnt_r == '0)
    else $error("counter did not wrap at reload");

  a_break_low: assert property (@(posedge sys_clk) disable iff (srst)
    breakActive |=> ~rawTwo_r & ~rawThree_r)
    else $error("break did not force outputs off");

  a_force_load: assert property (@(posedge sys_clk) disable iff (srst)
    onePulseOn & forceUpdateTwo |=> activeDutyThree_r == $past(dutyCompareThree)
      && activePolThree_r == $past(outputPolarityThree))
    else $error("force did not load active copies");

  a_pol_hold: assert property (@(posedge sys_clk) disable iff (srst)
    ~forceUpdateTwo & ~(clearCnt & transferEnableTwo) |=> $stable(activePolThree_r))
    else $error("polarity changed outside overflow");

endmodule

// ===== src/opt_pkg.sv
// constants for the one-pulse pwm timer
package opt_pkg;
  localparam int CNT_W = 12;
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [11:0] DUTY_RST = 12'h000;
  localparam logic [11:0] RELOAD_RST = 12'hFFF;
  // trigger to clear: two pipeline stages, third cycle is the clear
  localparam int TRIG_PIPE = 2;
  typedef enum logic [1:0] {
    OPT_EV_NONE,
    OPT_EV_PWM,
    OPT_EV_UNTRIG,
    OPT_EV_FORCE
  } opt_event_t;
endpackage

// ===== test/opt_trig_src.sv
// trigger pin source model for the capture pin
module opt_trig_src (
  // clock
  sys_clk,
  // request and pin
  pinLevel,
  captureTriggerPin
);
  timeunit 1ns;
  timeprecision 1ps;
  input wire logic sys_clk;
  input wire logic pinLevel;
  output logic captureTriggerPin;
  // pin moves just after an edge, as a synchronous source would
  initial captureTriggerPin = 1'b0;
  always @(posedge sys_clk) captureTriggerPin <= pinLevel;
endmodule

// ===== test/tb.sv
// self-checking bench for the one-pulse timer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, dualTimerMode, counterTwoEnable, onePulseEnable, triggerEdgeSelect;
  logic breakActive, counterTick, outputPolarityTwo, outputPolarityThree;
  logic transferEnableTwo, forceUpdateTwo, captureTriggerPin, pinLevel;
  logic pulseOutTwo, pulseOutThree, overflowTwo;
  logic [11:0] reloadValueTwo, dutyCompareTwo, dutyCompareThree, secondCounter;
  int bad_count, samples_checked, cycles;
  logic early;
  ////////////////////////////////////////////////////////////////
  opt_one_pulse_timer dut (.sys_clk(sys_clk), .srst(srst), .dualTimerMode(dualTimerMode),
    .counterTwoEnable(counterTwoEnable), .onePulseEnable(onePulseEnable),
    .triggerEdgeSelect(triggerEdgeSelect), .breakActive(breakActive),
    .counterTick(counterTick), .reloadValueTwo(reloadValueTwo),
    .dutyCompareTwo(dutyCompareTwo), .dutyCompareThree(dutyCompareThree),
    .outputPolarityTwo(outputPolarityTwo), .outputPolarityThree(outputPolarityThree),
    .transferEnableTwo(transferEnableTwo), .forceUpdateTwo(forceUpdateTwo),
    .captureTriggerPin(captureTriggerPin), .pulseOutTwo(pulseOutTwo),
    .pulseOutThree(pulseOutThree), .overflowTwo(overflowTwo), .secondCounter(secondCounter));
  opt_trig_src src (.sys_clk(sys_clk), .pinLevel(pinLevel),
    .captureTriggerPin(captureTriggerPin));
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_cnt(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // wait past duty match or for an overflow, move the pin, watch for a restart
  task automatic fire(input logic lvl, input bit afterOvf, input logic exp);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    while (n < 200 && (afterOvf ? overflowTwo !== 1'b1 : pulseOutThree !== 1'b0)) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    pinLevel <= lvl;
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      if (overflowTwo === 1'b1) seen = 1'b1;
    end
    check("restart", exp, seen);
    if (exp) check("outThree", 1'b1, pulseOutThree);
    if (exp) check("outTwo", 1'b1, pulseOutTwo);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    dualTimerMode = 1'b1;
    counterTwoEnable = 1'b1;
    onePulseEnable = 1'b1;
    triggerEdgeSelect = 1'b1;
    breakActive = 1'b0;
    counterTick = 1'b1;
    // entry order: enable, reload, duty, polarity, transfer
    // reload never changed during the run
    // capture interrupt lives outside this block, kept off
    reloadValueTwo = 12'h028;
    dutyCompareTwo = 12'h014;
    dutyCompareThree = 12'h010;
    outputPolarityTwo = 1'b0;
    outputPolarityThree = 1'b0;
    transferEnableTwo = 1'b1;
    forceUpdateTwo = 1'b0;
    pinLevel = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (4) @(posedge sys_clk);
    #1;
    check_cnt("resetCount", 12'h000, secondCounter);
    check("resetOut", 1'b0, pulseOutThree);
    @(posedge sys_clk);
    srst <= 1'b0;
    repeat (50) @(posedge sys_clk);
    fire(1'b1, 1'b0, 1'b1);
    fire(1'b0, 1'b0, 1'b0);
    fire(1'b1, 1'b1, 1'b1);
    early = 1'b0;
    @(posedge sys_clk);
    pinLevel <= 1'b0;
    @(posedge sys_clk);
    pinLevel <= 1'b1;
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      if (overflowTwo === 1'b1) early = 1'b1;
    end
    check("earlyEdge", 1'b0, early);
    @(posedge sys_clk);
    triggerEdgeSelect <= 1'b0;
    fire(1'b0, 1'b0, 1'b1);
    fire(1'b1, 1'b0, 1'b0);
    $display("edge tests done");
    @(posedge sys_clk);
    // one-pulse off first, counter left running
    onePulseEnable <= 1'b0;
    fire(1'b0, 1'b1, 1'b0);
    @(posedge sys_clk);
    onePulseEnable <= 1'b1;
    outputPolarityThree <= 1'b1;
    forceUpdateTwo <= 1'b1;
    @(posedge sys_clk);
    forceUpdateTwo <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("polThree", 1'b0, pulseOutThree);
    check("polTwo", 1'b1, pulseOutTwo);
    $display("force tests done");
    conclude();
  end
endmodule
